// ==== dsff_defs.svh ====
// Constants for the dual serial field FIFO
`ifndef DSFF_DEFS_SVH
`define DSFF_DEFS_SVH
`define DSFF_DATA_W 8
`define DSFF_ADDR_W 18
`define DSFF_DEPTH 262144
`define DSFF_PTR_RST 18'h00000
`define DSFF_BUF_DEPTH 2
`define DSFF_LINK_PERIOD_NS 320
`endif

// ==== dsff_pkg.sv ====
// Types for the dual serial field FIFO
`default_nettype none
package dsff_pkg;
  typedef logic [7:0] dsff_byte_t;
  typedef enum logic [1:0] {
    DSFF_IDLE = 2'b00,
    DSFF_RUN = 2'b01
  } dsff_mode_e;
endpackage
`default_nettype wire

// ==== dsff_mem_if.sv ====
// Memory port bundle between the control logic and the storage
`timescale 1ns/1ps
`default_nettype none
interface dsff_mem_if #(parameter int AW = 18);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ==== dsff_mem.sv ====
// Single port-pair storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module dsff_mem #(
  parameter int AW = 18,
  parameter int DEPTH = 262144
) (
  input wire logic clk_i,
  dsff_mem_if.mem m
);
  logic [7:0] store [0:DEPTH-1];
  logic [7:0] rdata_q;

  always_ff @(posedge clk_i)
  begin
    if (m.we)
    begin
      store[m.waddr] <= m.wdata;
    end
    rdata_q <= store[m.raddr];
  end

  assign m.rdata = rdata_q;
endmodule // dsff_mem
`default_nettype wire

// ==== dsff_top.sv ====
// Dual serial field FIFO control logic
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "dsff_defs.svh"
module dsff_top #(
  parameter int AW = `DSFF_ADDR_W,
  parameter int DEPTH = `DSFF_DEPTH
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic PORT1_WRITE_CLOCK_I,
  input wire logic PORT2_WRITE_CLOCK_I,
  input wire logic SHARED_READ_CLOCK_I,
  input wire logic PORT1_WRITE_GATE_I,
  input wire logic PORT2_WRITE_GATE_I,
  input wire logic PORT1_INPUT_MASK_I,
  input wire logic PORT2_INPUT_MASK_I,
  input wire logic PORT1_WRITE_POINTER_RESET_I,
  input wire logic PORT2_WRITE_POINTER_RESET_I,
  input wire dsff_pkg::dsff_byte_t PORT1_WRITE_BUS_I,
  input wire dsff_pkg::dsff_byte_t PORT2_WRITE_BUS_I,
  input wire logic PORT1_READ_GATE_I,
  input wire logic PORT2_READ_GATE_I,
  input wire logic PORT1_OUTPUT_GATE_I,
  input wire logic PORT2_OUTPUT_GATE_I,
  input wire logic PORT1_READ_POINTER_RESET_I,
  input wire logic PORT2_READ_POINTER_RESET_I,
  input wire logic CASCADE_SELECT_STRAP_I,
  input wire logic READ_READY_I,
  output var dsff_pkg::dsff_byte_t PORT1_READ_BUS_O,
  output var dsff_pkg::dsff_byte_t PORT2_READ_BUS_O,
  output var logic PORT1_READ_BUS_OE_O,
  output var logic PORT2_READ_BUS_OE_O,
  output var logic READ_VALID_O,
  output var logic WRITE_READY_O
);
  import dsff_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge finding
  // ----------------------------------------------------------------
  localparam int NS = 16;

  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [2:0] clk_prev;
    logic [1:0] wrst_armed;
    logic [1:0] rrst_armed;
    logic [1:0] wpend_rst;
    logic [1:0] wpend_adv;
    logic [1:0] wpend_st;
    logic [15:0] wpend_data;
    logic [1:0] rpend_rst;
    logic [1:0] rpend_adv;
    logic [1:0] rpend_sh;
    logic [1:0] rpend_oe;
    logic [AW-1:0] wptr1;
    logic [AW-1:0] wptr2;
    logic [AW-1:0] rptr1;
    logic [AW-1:0] rptr2;
    logic [1:0] rd_wait;
    logic [1:0] rd_oe;
    logic [1:0] bvalid;
    logic [1:0][17:0] bdata;
    logic bwr;
    logic brd;
    logic [7:0] out1;
    logic [7:0] out2;
    logic oe1;
    logic oe2;
    logic rvalid;
    logic wready;
  } dsff_state_s;

  dsff_state_s q, d;
  logic [NS-1:0] pins;

  assign pins = {CASCADE_SELECT_STRAP_I,
                 PORT2_READ_POINTER_RESET_I, PORT1_READ_POINTER_RESET_I,
                 PORT2_OUTPUT_GATE_I, PORT1_OUTPUT_GATE_I,
                 PORT2_READ_GATE_I, PORT1_READ_GATE_I,
                 PORT2_WRITE_POINTER_RESET_I, PORT1_WRITE_POINTER_RESET_I,
                 PORT2_INPUT_MASK_I, PORT1_INPUT_MASK_I,
                 PORT2_WRITE_GATE_I, PORT1_WRITE_GATE_I,
                 SHARED_READ_CLOCK_I, PORT2_WRITE_CLOCK_I, PORT1_WRITE_CLOCK_I};

  // Input byte buses are sampled beside the strobes
  logic [7:0] din1_s1, din1_s2, din2_s1, din2_s2;
  always_ff @(posedge CLOCK_I)
  begin
    din1_s1 <= PORT1_WRITE_BUS_I;
    din1_s2 <= din1_s1;
    din2_s1 <= PORT2_WRITE_BUS_I;
    din2_s2 <= din2_s1;
  end

  // ----------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------
  dsff_mem_if #(.AW(AW)) m1 ();
  dsff_mem_if #(.AW(AW)) m2 ();
  dsff_mem #(.AW(AW), .DEPTH(DEPTH)) u_mem1 (.clk_i(CLOCK_I), .m(m1.mem));
  dsff_mem #(.AW(AW), .DEPTH(DEPTH)) u_mem2 (.clk_i(CLOCK_I), .m(m2.mem));

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH - 1)) ? AW'(`DSFF_PTR_RST) : p + AW'(1);
  endfunction

  logic [1:0] wedge;
  logic redge;
  logic [1:0] wgate, wmask, wrst, rgate, ogate, rrst;
  logic cascade;
  logic [1:0] w_rst_now, w_adv_now, w_st_now;
  logic [1:0] r_rst_now, r_adv_now, r_sh_now, r_oe_now;
  logic [15:0] w_data_now;

  always_comb
  begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.clk_prev = q.s2[2:0];
    wedge = q.s2[1:0] & ~q.clk_prev[1:0];
    redge = q.s2[2] & ~q.clk_prev[2];
    wgate = q.s2[4:3];
    wmask = q.s2[6:5];
    wrst = q.s2[8:7];
    rgate = q.s2[10:9];
    ogate = q.s2[12:11];
    rrst = q.s2[14:13];
    cascade = q.s2[15];
    m1.we = 1'b0;
    m2.we = 1'b0;
    m1.waddr = q.wptr1;
    m2.waddr = q.wptr2;
    m1.wdata = 8'h00;
    m2.wdata = 8'h00;
    m1.raddr = q.rptr1;
    m2.raddr = q.rptr2;
    w_rst_now = 2'b00;
    w_adv_now = 2'b00;
    w_st_now = 2'b00;
    w_data_now = {din2_s2, din1_s2};
    r_rst_now = 2'b00;
    r_adv_now = 2'b00;
    r_sh_now = 2'b00;
    r_oe_now = ogate;

    // ----------------------------------------------------------------
    // Write side decode
    // ----------------------------------------------------------------
    for (int i = 0; i < 2; i++)
    begin
      if (wedge[i])
      begin
        if (wrst[i] && !q.wrst_armed[i])
        begin
          w_rst_now[i] = 1'b1;
        end
        else
        begin
          w_adv_now[i] = wgate[i];
          w_st_now[i] = wgate[i] & wmask[i];
        end
        d.wrst_armed[i] = wrst[i];
      end
    end

    // ----------------------------------------------------------------
    // Read side decode
    // ----------------------------------------------------------------
    if (redge)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (rrst[i] && !q.rrst_armed[i])
        begin
          r_rst_now[i] = 1'b1;
        end
        else
        begin
          r_adv_now[i] = rgate[i];
          r_sh_now[i] = rgate[i];
        end
        d.rrst_armed[i] = rrst[i];
      end
    end

    // Cascade defers the action one CLOCK_I cycle
    d.wpend_rst = w_rst_now;
    d.wpend_adv = w_adv_now;
    d.wpend_st = w_st_now;
    d.wpend_data = w_data_now;
    d.rpend_rst = r_rst_now;
    d.rpend_adv = r_adv_now;
    d.rpend_sh = r_sh_now;
    d.rpend_oe = r_oe_now;
    if (cascade)
    begin
      w_rst_now = q.wpend_rst;
      w_adv_now = q.wpend_adv;
      w_st_now = q.wpend_st;
      w_data_now = q.wpend_data;
      r_rst_now = q.rpend_rst;
      r_adv_now = q.rpend_adv;
      r_sh_now = q.rpend_sh;
      r_oe_now = q.rpend_oe;
    end

    // ----------------------------------------------------------------
    // Pointer and memory actions
    // ----------------------------------------------------------------
    m1.we = w_st_now[0];
    m1.wdata = w_data_now[7:0];
    m2.we = w_st_now[1];
    m2.wdata = w_data_now[15:8];
    if (w_rst_now[0])
    begin
      d.wptr1 = AW'(`DSFF_PTR_RST);
    end
    else if (w_adv_now[0])
    begin
      d.wptr1 = ptr_next(q.wptr1);
    end
    if (w_rst_now[1])
    begin
      d.wptr2 = AW'(`DSFF_PTR_RST);
    end
    else if (w_adv_now[1])
    begin
      d.wptr2 = ptr_next(q.wptr2);
    end
    if (r_rst_now[0])
    begin
      d.rptr1 = AW'(`DSFF_PTR_RST);
    end
    else if (r_adv_now[0])
    begin
      d.rptr1 = ptr_next(q.rptr1);
    end
    if (r_rst_now[1])
    begin
      d.rptr2 = AW'(`DSFF_PTR_RST);
    end
    else if (r_adv_now[1])
    begin
      d.rptr2 = ptr_next(q.rptr2);
    end

    // Registered memory data lands one cycle after the shift
    d.rd_wait = (|r_sh_now) ? 2'b01 : 2'b00;
    if (|r_sh_now)
    begin
      d.rd_oe = r_oe_now;
    end

    // ----------------------------------------------------------------
    // Two-entry output buffer
    // ----------------------------------------------------------------
    d.bwr = q.rd_wait[0] && !q.bvalid[1];
    d.wready = !(q.bvalid[1] || (q.bvalid[0] && d.bwr));
    d.brd = q.bvalid[0] && READ_READY_I;
    if (d.brd)
    begin
      d.out1 = q.bdata[0][7:0];
      d.out2 = q.bdata[0][15:8];
      d.oe1 = q.bdata[0][16];
      d.oe2 = q.bdata[0][17];
      d.bdata[0] = q.bdata[1];
      d.bvalid = {1'b0, q.bvalid[1]};
    end
    d.rvalid = d.brd;
    if (q.rd_wait[0] && !(d.bvalid[0] && d.bvalid[1]))
    begin
      if (!d.bvalid[0])
      begin
        d.bdata[0] = {q.rd_oe, m2.rdata, m1.rdata};
        d.bvalid[0] = 1'b1;
      end
      else
      begin
        d.bdata[1] = {q.rd_oe, m2.rdata, m1.rdata};
        d.bvalid[1] = 1'b1;
      end
    end
    d.bwr = q.rd_wait[0];
    d.brd = 1'b0;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign PORT1_READ_BUS_O = q.out1;
  assign PORT2_READ_BUS_O = q.out2;
  assign PORT1_READ_BUS_OE_O = q.oe1;
  assign PORT2_READ_BUS_OE_O = q.oe2;
  assign READ_VALID_O = q.rvalid;
  assign WRITE_READY_O = q.wready;
endmodule // dsff_top
`default_nettype wire

// ==== dsff_video_model.sv ====
// Video-side partner driving link clocks, gates and data
`timescale 1ns/1ps
`default_nettype none
module dsff_video_model
  import dsff_pkg::*;
(
  input wire logic clk_i,
  output logic [2:0] lclk_o,
  output logic [1:0] we_o,
  output logic [1:0] ie_o,
  output logic [1:0] wrst_o,
  output logic [1:0] re_o,
  output logic [1:0] oe_o,
  output logic [1:0] rrst_o,
  output dsff_pkg::dsff_byte_t d1_o,
  output dsff_pkg::dsff_byte_t d2_o
);
  initial
  begin
    {lclk_o, we_o, ie_o, wrst_o, re_o, oe_o, rrst_o} = '0;
    d1_o = 8'h5a;
    d2_o = 8'ha5;
  end

  // ----------------------------------------------------------------
  // One link frame: g is gate, input mask or output gate, pointer reset
  // ----------------------------------------------------------------
  task automatic cyc(input logic rd, input logic [2:0] g, input dsff_byte_t d);
    @(posedge clk_i);
    #1;
    if (rd)
      {re_o, oe_o, rrst_o} = {{2{g[2]}}, {2{g[1]}}, {2{g[0]}}};
    else
      {we_o, ie_o, wrst_o} = {{2{g[2]}}, {2{g[1]}}, {2{g[0]}}};
    d1_o = d;
    d2_o = d + 8'h80;
    repeat (4) @(posedge clk_i);
    #1 lclk_o = rd ? 3'h4 : 3'h3;
    repeat (4) @(posedge clk_i);
    #1 lclk_o = 3'h0;
    repeat (6) @(posedge clk_i);
    #1 wrst_o = 2'h0;
    rrst_o = 2'h0;
    d1_o = ~d1_o;
    d2_o = ~d2_o;
  endtask
endmodule // dsff_video_model
`default_nettype wire

// ==== dsff_top_chk.sv ====
// Assertions on the read side outputs
`timescale 1ns/1ps
`default_nettype none
module dsff_top_chk
  import dsff_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic SHARED_READ_CLOCK_I,
  input wire logic READ_READY_I,
  input wire dsff_pkg::dsff_byte_t PORT1_READ_BUS_O,
  input wire dsff_pkg::dsff_byte_t PORT2_READ_BUS_O,
  input wire logic PORT1_READ_BUS_OE_O,
  input wire logic PORT2_READ_BUS_OE_O,
  input wire logic READ_VALID_O
);
  logic [4:0] quiet_q;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // Cycles with read clock low and receiver ready
  always_ff @(posedge CLOCK_I)
    quiet_q <= (RST_I || SHARED_READ_CLOCK_I || !READ_READY_I) ? 5'h0 : quiet_q + {4'h0, quiet_q < 5'h14};

  chk_bus1_hold: assert property (!READ_VALID_O && !$past(RST_I) |-> $stable(PORT1_READ_BUS_O))
    else $error("port1 bus changed without a word");
  chk_bus2_hold: assert property (!READ_VALID_O && !$past(RST_I) |-> $stable(PORT2_READ_BUS_O))
    else $error("port2 bus changed without a word");
  chk_oe1_hold: assert property (!READ_VALID_O && !$past(RST_I) |-> $stable(PORT1_READ_BUS_OE_O))
    else $error("port1 enable changed without a word");
  chk_oe2_hold: assert property (!READ_VALID_O && !$past(RST_I) |-> $stable(PORT2_READ_BUS_OE_O))
    else $error("port2 enable changed without a word");
  chk_word_source: assert property (READ_VALID_O |-> quiet_q < 5'h10)
    else $error("word without a recent read edge");
  chk_min_latency: assert property (quiet_q >= 5'h08 && $rose(SHARED_READ_CLOCK_I) |-> !READ_VALID_O [*4])
    else $error("word too soon after read edge");
  chk_reset_clear: assert property ($fell(RST_I) |-> !READ_VALID_O && !PORT1_READ_BUS_OE_O && !PORT2_READ_BUS_OE_O)
    else $error("outputs active after reset");
  chk_ready_gate: assert property (READ_VALID_O |-> READ_READY_I || $past(READ_READY_I))
    else $error("word while receiver stalled");
  cover property (READ_VALID_O && !PORT1_READ_BUS_OE_O);
  cover property (READ_VALID_O && PORT2_READ_BUS_OE_O);
  cover property ($rose(READ_READY_I) ##[1:10] READ_VALID_O);
endmodule // dsff_top_chk
bind dsff_top dsff_top_chk i_dsff_top_chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
  .SHARED_READ_CLOCK_I(SHARED_READ_CLOCK_I), .READ_READY_I(READ_READY_I),
  .PORT1_READ_BUS_O(PORT1_READ_BUS_O), .PORT2_READ_BUS_O(PORT2_READ_BUS_O),
  .PORT1_READ_BUS_OE_O(PORT1_READ_BUS_OE_O), .PORT2_READ_BUS_OE_O(PORT2_READ_BUS_OE_O),
  .READ_VALID_O(READ_VALID_O));
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the dual serial field FIFO
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dsff_pkg::*;
  logic clk, rst, ready, valid, wready, o1, o2, casc;
  logic lc2_q = 1'b0;
  int rise_age = 0;
  int lat_got = 0;
  logic [2:0] lc;
  logic [1:0] we, ie, wr, re, oe, rr;
  dsff_byte_t d1, d2, q1, q2;
  logic [17:0] fifo[$];
  int err_count = 0;
  int comparisons = 0;

  dsff_video_model i_dsff_video_model (.clk_i(clk), .lclk_o(lc), .we_o(we), .ie_o(ie), .wrst_o(wr),
    .re_o(re), .oe_o(oe), .rrst_o(rr), .d1_o(d1), .d2_o(d2));
  dsff_top #(.AW(4), .DEPTH(16)) i_dsff_top (.CLOCK_I(clk), .RST_I(rst),
    .PORT1_WRITE_CLOCK_I(lc[0]), .PORT2_WRITE_CLOCK_I(lc[1]), .SHARED_READ_CLOCK_I(lc[2]),
    .PORT1_WRITE_GATE_I(we[0]), .PORT2_WRITE_GATE_I(we[1]), .PORT1_INPUT_MASK_I(ie[0]),
    .PORT2_INPUT_MASK_I(ie[1]), .PORT1_WRITE_POINTER_RESET_I(wr[0]), .PORT2_WRITE_POINTER_RESET_I(wr[1]),
    .PORT1_WRITE_BUS_I(d1), .PORT2_WRITE_BUS_I(d2), .PORT1_READ_GATE_I(re[0]), .PORT2_READ_GATE_I(re[1]),
    .PORT1_OUTPUT_GATE_I(oe[0]), .PORT2_OUTPUT_GATE_I(oe[1]), .PORT1_READ_POINTER_RESET_I(rr[0]),
    .PORT2_READ_POINTER_RESET_I(rr[1]), .CASCADE_SELECT_STRAP_I(casc), .READ_READY_I(ready),
    .PORT1_READ_BUS_O(q1), .PORT2_READ_BUS_O(q2), .PORT1_READ_BUS_OE_O(o1), .PORT2_READ_BUS_OE_O(o2),
    .READ_VALID_O(valid), .WRITE_READY_O(wready));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Collects read words and the cycles from read clock rise to word
  always @(posedge clk)
  begin
    lc2_q <= lc[2];
    rise_age <= (lc[2] && !lc2_q) ? 0 : rise_age + 1;
    if (valid === 1'b1)
    begin
      fifo.push_back({o1, o2, q1, q2});
      lat_got <= rise_age;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [17:0] w(input logic e, input dsff_byte_t d);
    return {e, e, d, d + 8'h80};
  endfunction

  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_int(input int got, input int exp);
    comparisons++;
    if (got != exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t latency %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic take(input logic [17:0] exp, input logic [17:0] msk);
    for (int n = 0; n < 40 && fifo.size() == 0; n++)
    begin
      @(posedge clk);
      #1;
    end
    if (fifo.size() == 0)
    begin
      err_count++;
      $display("CHECK FAILED %0t no read word", $time);
      tally_and_finish();
    end
    else
    begin
      cmp(fifo.pop_front() & msk, exp & msk);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    ready = 1'b1;
    casc = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge clk);
    #1 i_dsff_video_model.cyc(1'b0, 3'b001, 8'h00);
    for (int i = 0; i < 16; i++)
      i_dsff_video_model.cyc(1'b0, 3'b110, 8'h10 + i[7:0]);
    i_dsff_video_model.cyc(1'b0, 3'b001, 8'h00);
    i_dsff_video_model.cyc(1'b0, 3'b110, 8'h20);
    i_dsff_video_model.cyc(1'b0, 3'b100, 8'h21);
    i_dsff_video_model.cyc(1'b0, 3'b010, 8'hee);
    i_dsff_video_model.cyc(1'b0, 3'b110, 8'h22);
    i_dsff_video_model.cyc(1'b1, 3'b001, 8'h00);
    fifo.delete();
    i_dsff_video_model.cyc(1'b1, 3'b110, 8'h00);
    take(w(1'b1, 8'h20), 18'h3ffff);
    cmp_int(lat_got, 4);
    i_dsff_video_model.cyc(1'b1, 3'b010, 8'h00);
    i_dsff_video_model.cyc(1'b1, 3'b100, 8'h00);
    take(w(1'b0, 8'h11), 18'h30000);
    i_dsff_video_model.cyc(1'b1, 3'b110, 8'h00);
    take(w(1'b1, 8'h22), 18'h3ffff);
    for (int i = 3; i < 16; i++)
      i_dsff_video_model.cyc(1'b1, 3'b110, 8'h00);
    fifo.delete();
    i_dsff_video_model.cyc(1'b1, 3'b110, 8'h00);
    take(w(1'b1, 8'h20), 18'h3ffff);
    ready = 1'b0;
    i_dsff_video_model.cyc(1'b1, 3'b110, 8'h00);
    i_dsff_video_model.cyc(1'b1, 3'b110, 8'h00);
    cmp({17'h0, wready}, 18'h0);
    ready = 1'b1;
    take(w(1'b1, 8'h11), 18'h3ffff);
    take(w(1'b1, 8'h22), 18'h3ffff);
    // Cascade run: strap changes only while the block is held in reset
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 casc = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge clk);
    i_dsff_video_model.cyc(1'b0, 3'b001, 8'h00);
    i_dsff_video_model.cyc(1'b0, 3'b110, 8'h33);
    i_dsff_video_model.cyc(1'b1, 3'b001, 8'h00);
    fifo.delete();
    i_dsff_video_model.cyc(1'b1, 3'b110, 8'h00);
    take(w(1'b1, 8'h33), 18'h3ffff);
    cmp_int(lat_got, 5);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
